// ### src/gpp_defines.svh
// Purpose: Offsets, field positions and reset values of the port block
// Assumes: Registers are 8 bits wide, one aligned word each
// Notes:   Included by its bare name
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// Register byte offsets
`define GPP_OFF_WIDE_DIR    8'h00
`define GPP_OFF_WIDE_DATA   8'h04
`define GPP_OFF_NARROW_DATA 8'h08
`define GPP_OFF_NARROW_DIR  8'h0c
`define GPP_OFF_NARROW_FSEL 8'h10

// Function select field positions
`define GPP_FSEL_PULSE_ONE  0
`define GPP_FSEL_PULSE_TWO  1
`define GPP_FSEL_IRQ_FOUR   2
`define GPP_FSEL_RSVD       3

// Reset values
`define GPP_RST_WIDE_DIR    8'h00
`define GPP_RST_WIDE_DATA   8'h00
`define GPP_RST_NARROW_DATA 4'hf
`define GPP_RST_NARROW_DIR  4'h0
`define GPP_RST_NARROW_FSEL 4'h0

// Fixed read values
`define GPP_WIDE_DIR_READ   8'hff
`define GPP_NARROW_DIR_READ 4'hf
`define GPP_RESV_HIGH       4'hf

`endif

// ### src/gpp_pkg.sv
// Purpose: Types shared by the port block
// Assumes: Nothing
// Notes:   Constants live in gpp_defines.svh
package gpp_pkg;

  typedef enum logic [2:0] {
    GPP_SEL_WIDE_DIR    = 3'h0,
    GPP_SEL_WIDE_DATA   = 3'h1,
    GPP_SEL_NARROW_DATA = 3'h2,
    GPP_SEL_NARROW_DIR  = 3'h3,
    GPP_SEL_NARROW_FSEL = 3'h4,
    GPP_SEL_NONE        = 3'h7
  } gpp_sel_t;

  typedef enum logic [1:0] {
    GPP_RESP_OKAY   = 2'b00,
    GPP_RESP_SLVERR = 2'b10
  } gpp_resp_t;

endpackage

// ### src/gpp_sync.sv
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to aclk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module gpp_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_reg <= '0;
      dout      <= '0;
    end else begin
      stage_reg <= din;
      dout      <= stage_reg;
    end
  end

endmodule // gpp_sync

// ### src/gpp_pin_mux.sv
// Purpose: Pin function routing of the four-bit port
// Assumes: Function select, direction and latch come from registers
// Notes:   Combinational; the top registers its outputs
`timescale 1ns/1ps
`include "gpp_defines.svh"
module gpp_pin_mux (
  // Register state
  input  wire logic [3:0] fsel,
  input  wire logic [3:0] dir,
  input  wire logic [3:0] data,
  // Synchronised pin levels
  input  wire logic [3:0] pin_sync,
  // Pulse generator levels
  input  wire logic       pulse_one_i,
  input  wire logic       pulse_two_i,
  // Routed results
  output logic      [3:0] pin_o_next,
  output logic      [3:0] pin_oe_next,
  output logic            irq_next
);

  always_comb begin
    // Plain port use on every pin first
    pin_oe_next = dir;
    pin_o_next  = data & dir;
    if (fsel[`GPP_FSEL_PULSE_ONE]) begin
      pin_oe_next[0] = 1'b1;
      pin_o_next[0]  = pulse_one_i;
    end
    if (fsel[`GPP_FSEL_PULSE_TWO]) begin
      pin_oe_next[1] = 1'b1;
      pin_o_next[1]  = pulse_two_i;
    end
    if (fsel[`GPP_FSEL_IRQ_FOUR]) begin
      pin_oe_next[2] = 1'b0;
      pin_o_next[2]  = 1'b0;
    end
    irq_next = fsel[`GPP_FSEL_IRQ_FOUR] & pin_sync[2];
  end

endmodule // gpp_pin_mux

// ### src/gpp_top.sv
// Purpose: Eight-bit port direction control and four-bit port with
//          function select, registers over AXI4-Lite
// Assumes: Single clock aclk, synchronous active-low aresetn
// Notes:   Pin outputs and enables are registered
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "gpp_defines.svh"

// Notes on behaviour
// - Wide direction bit 1 makes pin output, 0 input, per pin.
// - Wide direction register is write-only; reads return all ones.
// - Wide direction and data apply only to pins in port use.
// - Narrow registers bits 7 to 4 read as one, ignore writes.
// - Narrow data latch low four bits are read and written.
// - Narrow data read gives latch for outputs, pin level for inputs.
// - Narrow direction bit 1 makes pin output, 0 input.
// - Narrow direction and data apply only to pins in port use.
// - Narrow direction register is write-only; reads return all ones.
// - Function select bit 2 routes pin two to interrupt four input.
// - Function select bits 1, 0 route pins 1, 0 to pulse outputs.
// - Pulse select overrides direction; else direction chooses.
// - Pin three is plain port; direction alone decides.
// - Wide data read gives latch for outputs, pin level for inputs.
module gpp_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // AXI4-Lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  // AXI4-Lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  // AXI4-Lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // Eight-bit port
  input  wire logic [7:0]  wide_gpio_sel,
  input  wire logic [7:0]  wide_pin_i,
  output logic      [7:0]  wide_pin_o,
  output logic      [7:0]  wide_pin_oe,
  // Four-bit port
  input  wire logic [3:0]  narrow_pin_i,
  output logic      [3:0]  narrow_pin_o,
  output logic      [3:0]  narrow_pin_oe,
  // Alternate functions
  input  wire logic        pulse_one_i,
  input  wire logic        pulse_two_i,
  output logic             ext_ext_interrupt_four_select_o
);

  // Address decode shared by write and read
  function automatic gpp_pkg::gpp_sel_t decode(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    unique case (a)
      `GPP_OFF_WIDE_DIR:    decode = gpp_pkg::GPP_SEL_WIDE_DIR;
      `GPP_OFF_WIDE_DATA:   decode = gpp_pkg::GPP_SEL_WIDE_DATA;
      `GPP_OFF_NARROW_DATA: decode = gpp_pkg::GPP_SEL_NARROW_DATA;
      `GPP_OFF_NARROW_DIR:  decode = gpp_pkg::GPP_SEL_NARROW_DIR;
      `GPP_OFF_NARROW_FSEL: decode = gpp_pkg::GPP_SEL_NARROW_FSEL;
      default:              decode = gpp_pkg::GPP_SEL_NONE;
    endcase
  endfunction

  logic               aw_hold_reg, w_hold_reg, w_strb0_reg;
  logic [7:0]         aw_addr_reg;
  logic [31:0]        w_data_reg, rdata_reg;
  logic               bvalid_reg, rvalid_reg;
  gpp_pkg::gpp_resp_t bresp_reg, rresp_reg;
  logic               wr_fire, wr_ok, ar_fire, irq_next;
  gpp_pkg::gpp_sel_t  wr_sel, rd_sel;
  logic [7:0]         rd_value, wide_dir_reg, wide_data_reg;
  logic [3:0]         narrow_data_reg, narrow_dir_reg, narrow_fsel_reg;
  logic [7:0]         wide_pin_sync, wide_o_next, wide_oe_next;
  logic [3:0]         narrow_pin_sync, narrow_o_next, narrow_oe_next;
  logic [7:0]         wide_pin_o_reg, wide_pin_oe_reg;
  logic [3:0]         narrow_pin_o_reg, narrow_pin_oe_reg;
  logic               ext_ext_interrupt_four_select_reg;

  // Bus handshakes
  assign awready = !aw_hold_reg && !bvalid_reg;
  assign wready  = !w_hold_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_ok   = wr_fire && w_strb0_reg;
  assign wr_sel  = decode(aw_addr_reg);
  assign ar_fire = arvalid && arready;
  assign rd_sel  = decode(araddr);
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // Write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb0_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold_reg  <= 1'b1;
      w_data_reg  <= wdata;
      w_strb0_reg <= wstrb[0];
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= gpp_pkg::GPP_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_sel == gpp_pkg::GPP_SEL_NONE) ?
                    gpp_pkg::GPP_RESP_SLVERR : gpp_pkg::GPP_RESP_OKAY;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Eight-bit port registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_dir_reg  <= `GPP_RST_WIDE_DIR;
      wide_data_reg <= `GPP_RST_WIDE_DATA;
    end else if (wr_ok && wr_sel == gpp_pkg::GPP_SEL_WIDE_DIR) begin
      wide_dir_reg <= w_data_reg[7:0];
    end else if (wr_ok && wr_sel == gpp_pkg::GPP_SEL_WIDE_DATA) begin
      wide_data_reg <= w_data_reg[7:0];
    end
  end

  // Four-bit port registers; upper bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      narrow_data_reg <= `GPP_RST_NARROW_DATA;
      narrow_dir_reg  <= `GPP_RST_NARROW_DIR;
      narrow_fsel_reg <= `GPP_RST_NARROW_FSEL;
    end else if (wr_ok) begin
      unique case (wr_sel)
        gpp_pkg::GPP_SEL_NARROW_DATA:
          narrow_data_reg <= w_data_reg[3:0];
        gpp_pkg::GPP_SEL_NARROW_DIR:
          narrow_dir_reg <= w_data_reg[3:0];
        gpp_pkg::GPP_SEL_NARROW_FSEL:
          narrow_fsel_reg <= w_data_reg[3:0];
        default: ;
      endcase
    end
  end

  // Read value selection
  always_comb begin
    unique case (rd_sel)
      gpp_pkg::GPP_SEL_WIDE_DIR:
        rd_value = `GPP_WIDE_DIR_READ;
      gpp_pkg::GPP_SEL_WIDE_DATA:
        rd_value = (wide_data_reg & wide_dir_reg) |
                   (wide_pin_sync & ~wide_dir_reg);
      gpp_pkg::GPP_SEL_NARROW_DATA:
        rd_value = {`GPP_RESV_HIGH, (narrow_data_reg & narrow_dir_reg) |
                   (narrow_pin_sync & ~narrow_dir_reg)};
      gpp_pkg::GPP_SEL_NARROW_DIR:
        rd_value = {`GPP_RESV_HIGH, `GPP_NARROW_DIR_READ};
      gpp_pkg::GPP_SEL_NARROW_FSEL:
        rd_value = {`GPP_RESV_HIGH, narrow_fsel_reg};
      default:
        rd_value = 8'h00;
    endcase
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= gpp_pkg::GPP_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h000000, rd_value};
      rresp_reg  <= (rd_sel == gpp_pkg::GPP_SEL_NONE) ?
                    gpp_pkg::GPP_RESP_SLVERR : gpp_pkg::GPP_RESP_OKAY;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Pin level synchronisers
  gpp_sync #(.WIDTH (8)) u_wide_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (wide_pin_i),
    .dout    (wide_pin_sync)
  );
  gpp_sync #(.WIDTH (4)) u_narrow_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (narrow_pin_i),
    .dout    (narrow_pin_sync)
  );

  // Eight-bit port drivers
  for (genvar i = 0; i < 8; i++) begin : g_wide
    assign wide_oe_next[i] = wide_dir_reg[i] &
                             wide_gpio_sel[i];
    assign wide_o_next[i]  = wide_oe_next[i] & wide_data_reg[i];
  end

  // Four-bit port routing
  gpp_pin_mux u_mux (
    .fsel        (narrow_fsel_reg),
    .dir         (narrow_dir_reg),
    .data        (narrow_data_reg),
    .pin_sync    (narrow_pin_sync),
    .pulse_one_i (pulse_one_i),
    .pulse_two_i (pulse_two_i),
    .pin_o_next  (narrow_o_next),
    .pin_oe_next (narrow_oe_next),
    .irq_next    (irq_next)
  );

  // Registered pin outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_pin_o_reg    <= 8'h00;
      wide_pin_oe_reg   <= 8'h00;
      narrow_pin_o_reg  <= 4'h0;
      narrow_pin_oe_reg <= 4'h0;
      ext_ext_interrupt_four_select_reg      <= 1'b0;
    end else begin
      wide_pin_o_reg    <= wide_o_next;
      wide_pin_oe_reg   <= wide_oe_next;
      narrow_pin_o_reg  <= narrow_o_next;
      narrow_pin_oe_reg <= narrow_oe_next;
      ext_ext_interrupt_four_select_reg      <= irq_next;
    end
  end

  assign wide_pin_o    = wide_pin_o_reg;
  assign wide_pin_oe   = wide_pin_oe_reg;
  assign narrow_pin_o  = narrow_pin_o_reg;
  assign narrow_pin_oe = narrow_pin_oe_reg;
  assign ext_ext_interrupt_four_select_o    = ext_ext_interrupt_four_select_reg;

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wide_dir_wr;
    wr_ok && wr_sel == gpp_pkg::GPP_SEL_WIDE_DIR;
  endsequence
  sequence s_narrow_data_wr;
    wr_ok && wr_sel == gpp_pkg::GPP_SEL_NARROW_DATA;
  endsequence

  a_wide_dir_drive:
    assert property (s_wide_dir_wr ##2 1 |->
      wide_pin_oe == ($past(w_data_reg[7:0], 2) & $past(wide_gpio_sel)))
    else $error("wide direction write not reflected on enables");
  a_wide_dir_ones:
    assert property (ar_fire && rd_sel == gpp_pkg::GPP_SEL_WIDE_DIR |=>
      rvalid && rdata == 32'h000000ff)
    else $error("wide direction read not all ones");
  a_wide_gpio_gate:
    assert property ((wide_pin_oe & ~$past(wide_gpio_sel)) == 8'h00)
    else $error("wide pin driven while not in port use");
  a_narrow_resv_ones:
    assert property (ar_fire && (rd_sel == gpp_pkg::GPP_SEL_NARROW_DATA ||
      rd_sel == gpp_pkg::GPP_SEL_NARROW_FSEL) |=> rdata[7:4] == 4'hf)
    else $error("narrow reserved bits not read as one");
  a_narrow_data_rw:
    assert property (s_narrow_data_wr |=>
      narrow_data_reg == $past(w_data_reg[3:0]))
    else $error("narrow data latch not updated");
  a_narrow_read_mix:
    assert property (ar_fire && rd_sel == gpp_pkg::GPP_SEL_NARROW_DATA |=>
      rdata[3:0] == $past((narrow_data_reg & narrow_dir_reg) |
                          (narrow_pin_sync & ~narrow_dir_reg)))
    else $error("narrow data read mix wrong");
  a_narrow_dir_ones:
    assert property (ar_fire && rd_sel == gpp_pkg::GPP_SEL_NARROW_DIR |=>
      rdata == 32'h000000ff)
    else $error("narrow direction read not all ones");
  a_irq_pin_route:
    assert property ($past(narrow_fsel_reg[2]) |->
      !narrow_pin_oe[2] && ext_ext_interrupt_four_select_o == $past(narrow_pin_sync[2]))
    else $error("interrupt pin routing wrong");
  a_pulse_pin_route:
    assert property ($past(narrow_fsel_reg[1:0]) == 2'b11 |->
      narrow_pin_oe[1:0] == 2'b11 &&
      narrow_pin_o[1:0] == {$past(pulse_two_i), $past(pulse_one_i)})
    else $error("pulse pin routing wrong");
  a_plain_pin_dir:
    assert property (narrow_pin_oe[3] == $past(narrow_dir_reg[3]) &&
      ($past(narrow_fsel_reg[0]) ||
       narrow_pin_oe[0] == $past(narrow_dir_reg[0])))
    else $error("narrow pin direction not followed");
  a_wide_read_mix:
    assert property (ar_fire && rd_sel == gpp_pkg::GPP_SEL_WIDE_DATA |=>
      rdata[7:0] == $past((wide_data_reg & wide_dir_reg) |
                          (wide_pin_sync & ~wide_dir_reg)))
    else $error("wide data read mix wrong");
  a_gpio_drive_latch:
    assert property ((wide_pin_o == ($past(wide_data_reg) & wide_pin_oe)) &&
      (narrow_pin_o[3] == ($past(narrow_data_reg[3]) & narrow_pin_oe[3])))
    else $error("port output not driving latch value");

endmodule // gpp_top

// ### tb/gpp_ext_ckt.sv
// Purpose: External circuitry on the pins of both ports
// Assumes: Undriven pins follow the level applied from outside
// Notes:   A pin driven by the block reads back what the block drives
`timescale 1ns/1ps
module gpp_ext_ckt (
  // Block pin drivers
  input  wire logic [7:0] wide_pin_o,
  input  wire logic [7:0] wide_pin_oe,
  input  wire logic [3:0] narrow_pin_o,
  input  wire logic [3:0] narrow_pin_oe,
  // Levels applied by outside sources
  input  wire logic [7:0] wide_lvl,
  input  wire logic [3:0] narrow_lvl,
  // Resolved pin levels
  output logic      [7:0] wide_pin_i,
  output logic      [3:0] narrow_pin_i
);
  // Driven pins show the block's value, others the outside level
  assign wide_pin_i   = (wide_pin_oe & wide_pin_o) |
                        (~wide_pin_oe & wide_lvl);
  assign narrow_pin_i = (narrow_pin_oe & narrow_pin_o) |
                        (~narrow_pin_oe & narrow_lvl);
endmodule // gpp_ext_ckt

// ### tb/gpp_port8_dir_port9_mux_tb.sv
// Purpose: Register and pin tests of the port block
// Assumes: AXI4-Lite master tasks, external circuitry model on pins
// Notes:   Expected values worked out from the register map
`timescale 1ns/1ps
`include "gpp_defines.svh"
module gpio_port8_dir_port9_mux_tb;
  logic        aclk, aresetn;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  wide_gpio_sel, wide_pin_i, wide_pin_o, wide_pin_oe, wide_lvl;
  logic [3:0]  narrow_pin_i, narrow_pin_o, narrow_pin_oe, narrow_lvl;
  logic        pulse_one_i, pulse_two_i, ext_ext_interrupt_four_select_o;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          err_count, comparisons;
  localparam logic [31:0] SLV = 32'(gpp_pkg::GPP_RESP_SLVERR);

  gpp_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wide_gpio_sel(wide_gpio_sel), .wide_pin_i(wide_pin_i),
    .wide_pin_o(wide_pin_o), .wide_pin_oe(wide_pin_oe),
    .narrow_pin_i(narrow_pin_i), .narrow_pin_o(narrow_pin_o),
    .narrow_pin_oe(narrow_pin_oe), .pulse_one_i(pulse_one_i),
    .pulse_two_i(pulse_two_i), .ext_ext_interrupt_four_select_o(ext_ext_interrupt_four_select_o));

  gpp_ext_ckt ext_u (.wide_pin_o(wide_pin_o), .wide_pin_oe(wide_pin_oe),
    .narrow_pin_o(narrow_pin_o), .narrow_pin_oe(narrow_pin_oe),
    .wide_lvl(wide_lvl), .narrow_lvl(narrow_lvl),
    .wide_pin_i(wide_pin_i), .narrow_pin_i(narrow_pin_i));

  always #10 aclk = ~aclk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'hff_ff_ff, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  // Bus read: address held until taken, data taken at rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rsp);
    chk(rd, exp);
    chk({30'h0, rsp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(a, d, 4'hf, rsp);
    chk({30'h0, rsp}, 32'h0);
    repeat (3) @(posedge aclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    tally_and_finish;
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    wide_gpio_sel = 8'hf0;
    wide_lvl = 8'h5a;
    narrow_lvl = 4'h2;
    pulse_one_i = 1'b1;
    pulse_two_i = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    // Reset state of registers and pins
    chk({20'h0, wide_pin_oe, narrow_pin_oe}, 32'h0);
    rd_chk(`GPP_OFF_WIDE_DIR, 32'hff);
    rd_chk(`GPP_OFF_WIDE_DATA, 32'h5a);
    rd_chk(`GPP_OFF_NARROW_DATA, 32'hf2);
    rd_chk(`GPP_OFF_NARROW_DIR, 32'hff);
    rd_chk(`GPP_OFF_NARROW_FSEL, 32'hf0);
    // Unmapped address refused
    axi_rd(8'h14, rd, rsp);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, SLV);
    axi_wr(8'h14, 8'h55, 4'hf, rsp);
    chk({30'h0, rsp}, SLV);
    // Wide port: direction per pin, gated by port use
    wr(`GPP_OFF_WIDE_DATA, 8'ha5);
    wr(`GPP_OFF_WIDE_DIR, 8'h3c);
    chk({24'h0, wide_pin_oe}, 32'h30);
    chk({24'h0, wide_pin_o}, 32'h20);
    rd_chk(`GPP_OFF_WIDE_DIR, 32'hff);
    rd_chk(`GPP_OFF_WIDE_DATA, 32'h66);
    // Strobe low is answered OKAY and leaves the latch alone
    axi_wr(`GPP_OFF_WIDE_DATA, 8'h00, 4'h0, rsp);
    chk({30'h0, rsp}, 32'h0);
    rd_chk(`GPP_OFF_WIDE_DATA, 32'h66);
    // Narrow port data and direction
    wr(`GPP_OFF_NARROW_DATA, 8'h05);
    rd_chk(`GPP_OFF_NARROW_DATA, 32'hf2);
    wr(`GPP_OFF_NARROW_DIR, 8'h0c);
    chk({28'h0, narrow_pin_oe}, 32'hc);
    chk({28'h0, narrow_pin_o}, 32'h4);
    rd_chk(`GPP_OFF_NARROW_DATA, 32'hf6);
    rd_chk(`GPP_OFF_NARROW_DIR, 32'hff);
    // Pulse outputs override direction; bit 3 kept clear
    wr(`GPP_OFF_NARROW_FSEL, 8'h03);
    rd_chk(`GPP_OFF_NARROW_FSEL, 32'hf3);
    chk({24'h0, narrow_pin_oe, narrow_pin_o}, 32'hf5);
    pulse_one_i <= 1'b0;
    pulse_two_i <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({24'h0, narrow_pin_oe, narrow_pin_o}, 32'hf6);
    // Latch and direction do not reach pins 1, 0 under pulse select
    wr(`GPP_OFF_NARROW_DIR, 8'h0f);
    chk({24'h0, narrow_pin_oe, narrow_pin_o}, 32'hf6);
    rd_chk(`GPP_OFF_NARROW_DATA, 32'hf5);
    wr(`GPP_OFF_NARROW_DIR, 8'h0c);
    wr(`GPP_OFF_NARROW_FSEL, 8'h00);
    chk({24'h0, narrow_pin_oe, narrow_pin_o}, 32'hc4);
    // Interrupt input on pin two, direction kept at zero
    wr(`GPP_OFF_NARROW_DIR, 8'h08);
    narrow_lvl <= 4'h6;
    repeat (5) @(posedge aclk);
    chk({31'h0, ext_ext_interrupt_four_select_o}, 32'h0);
    wr(`GPP_OFF_NARROW_FSEL, 8'h04);
    repeat (2) @(posedge aclk);
    chk({27'h0, narrow_pin_oe, ext_ext_interrupt_four_select_o}, 32'h11);
    narrow_lvl <= 4'h2;
    repeat (5) @(posedge aclk);
    chk({31'h0, ext_ext_interrupt_four_select_o}, 32'h0);
    rd_chk(`GPP_OFF_NARROW_FSEL, 32'hf4);
    tally_and_finish;
  end
endmodule // gpio_port8_dir_port9_mux_tb
